// file: core/poe_bank.sv
// APB slave holding the three port output-enable and data registers
`timescale 1ns/100ps
`default_nettype none
`include "poe_consts.svh"

module poe_bank
    import poe_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [`POE_AW-1:0]   paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`POE_DW-1:0]   pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [`POE_DW-1:0]   prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [`POE_A_W-1:0]  first_port_pad_in,
    output logic      [`POE_A_W-1:0]  first_port_pad_out,
    output logic      [`POE_A_W-1:0]  first_port_pad_oe,
    input  wire logic [`POE_B_W-1:0]  second_port_pad_in,
    output logic      [`POE_B_W-1:0]  second_port_pad_out,
    output logic      [`POE_B_W-1:0]  second_port_pad_oe,
    input  wire logic [`POE_C_W-1:0]  third_port_pad_in,
    output logic      [`POE_C_W-1:0]  third_port_pad_out,
    output logic      [`POE_C_W-1:0]  third_port_pad_oe
);

    // ****************************************
    // Declarations
    // ****************************************
    poe_state_t         state_r;
    poe_state_t         state_nxt;
    poe_sel_t           sel_r;
    poe_sel_t           sel_nxt;
    poe_sel_t           addr_sel;
    logic               err_r;
    logic               err_nxt;
    logic [`POE_DW-1:0] prdata_r;
    logic [`POE_DW-1:0] prdata_nxt;
    logic [`POE_DW-1:0] rd_word;
    logic               setup_phase;
    logic               access_done;
    logic               wr_commit;

    // Port slice links
    poe_port_if first_port_regs ();
    poe_port_if second_port_regs ();
    poe_port_if third_port_regs ();

    // ****************************************
    // Address decode
    // ****************************************
    // Full compare: any other address, misaligned
    // or not, is unmapped and answers with an error
    always_comb begin
        case (paddr)
            {`POE_IDX_A_LAT, `POE_WORD_LSB}: begin
                addr_sel = SEL_A_LAT;
            end
            {`POE_IDX_A_DRV, `POE_WORD_LSB}: begin
                addr_sel = SEL_A_DRV;
            end
            {`POE_IDX_B_LAT, `POE_WORD_LSB}: begin
                addr_sel = SEL_B_LAT;
            end
            {`POE_IDX_B_DRV, `POE_WORD_LSB}: begin
                addr_sel = SEL_B_DRV;
            end
            {`POE_IDX_C_LAT, `POE_WORD_LSB}: begin
                addr_sel = SEL_C_LAT;
            end
            {`POE_IDX_C_DRV, `POE_WORD_LSB}: begin
                addr_sel = SEL_C_DRV;
            end
            default: begin
                addr_sel = SEL_NONE;
            end
        endcase
    end

    // ****************************************
    // Bus phase tracking
    // ****************************************
    // Setup is psel without penable; the slave
    // never stretches, so access lasts one cycle
    assign setup_phase = psel & ~penable;
    assign access_done = (state_r == ST_ACCESS) & psel & penable;

    // Phase follows the master; a setup right
    // after an access is caught from idle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (setup_phase) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (setup_phase) begin
                    state_nxt = ST_ACCESS;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Read data selection
    // ****************************************
    // Narrow registers sit in the low byte and
    // everything above reads as zero
    always_comb begin
        rd_word = `POE_RDATA_RST;
        case (addr_sel)
            SEL_A_LAT: begin
                rd_word[`POE_BYTE] = first_port_regs.latch_rd;
            end
            SEL_A_DRV: begin
                rd_word[`POE_BYTE] = first_port_regs.drive_rd;
            end
            SEL_B_LAT: begin
                rd_word[`POE_BYTE] = second_port_regs.latch_rd;
            end
            SEL_B_DRV: begin
                rd_word[`POE_BYTE] = second_port_regs.drive_rd;
            end
            SEL_C_LAT: begin
                rd_word[`POE_BYTE] = third_port_regs.latch_rd;
            end
            SEL_C_DRV: begin
                rd_word[`POE_BYTE] = third_port_regs.drive_rd;
            end
            default: begin
                rd_word = `POE_RDATA_RST;
            end
        endcase
    end

    // ****************************************
    // Setup capture
    // ****************************************
    // Select, error and read data are frozen in
    // setup so prdata comes from a flop in access
    always_comb begin
        sel_nxt    = sel_r;
        err_nxt    = err_r;
        prdata_nxt = prdata_r;
        if (setup_phase) begin
            sel_nxt = addr_sel;
            err_nxt = (addr_sel == SEL_NONE);
            if (!pwrite) begin
                prdata_nxt = rd_word;
            end else begin
                prdata_nxt = `POE_RDATA_RST;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r    <= SEL_NONE;
            err_r    <= 1'b0;
            prdata_r <= `POE_RDATA_RST;
        end else begin
            sel_r    <= sel_nxt;
            err_r    <= err_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ****************************************
    // Write strobes
    // ****************************************
    // A write lands only at the access edge, only
    // with lane 0 strobed, and never on an error
    assign wr_commit = access_done & pwrite & ~err_r
                     & pstrb[`POE_LANE0];

    // One strobe per register; the slices keep
    // only their own width of the byte
    always_comb begin
        first_port_regs.wr_latch  = 1'b0;
        first_port_regs.wr_drive  = 1'b0;
        second_port_regs.wr_latch = 1'b0;
        second_port_regs.wr_drive = 1'b0;
        third_port_regs.wr_latch  = 1'b0;
        third_port_regs.wr_drive  = 1'b0;
        if (wr_commit) begin
            case (sel_r)
                SEL_A_LAT: begin
                    first_port_regs.wr_latch = 1'b1;
                end
                SEL_A_DRV: begin
                    first_port_regs.wr_drive = 1'b1;
                end
                SEL_B_LAT: begin
                    second_port_regs.wr_latch = 1'b1;
                end
                SEL_B_DRV: begin
                    second_port_regs.wr_drive = 1'b1;
                end
                SEL_C_LAT: begin
                    third_port_regs.wr_latch = 1'b1;
                end
                SEL_C_DRV: begin
                    third_port_regs.wr_drive = 1'b1;
                end
                default: begin
                    first_port_regs.wr_latch = 1'b0;
                end
            endcase
        end
    end

    // Same byte goes to every slice
    assign first_port_regs.wdata  = pwdata[`POE_BYTE];
    assign second_port_regs.wdata = pwdata[`POE_BYTE];
    assign third_port_regs.wdata  = pwdata[`POE_BYTE];

    // ****************************************
    // Port slices
    // ****************************************
    // First port, six pins
    poe_port #(
        .W       (`POE_A_W)
    ) u_first_port (
        .pclk    (pclk),
        .presetn (presetn),
        .regs    (first_port_regs.port),
        .pad_in  (first_port_pad_in),
        .pad_out (first_port_pad_out),
        .pad_oe  (first_port_pad_oe)
    );

    // Second port, eight pins
    poe_port #(
        .W       (`POE_B_W)
    ) u_second_port (
        .pclk    (pclk),
        .presetn (presetn),
        .regs    (second_port_regs.port),
        .pad_in  (second_port_pad_in),
        .pad_out (second_port_pad_out),
        .pad_oe  (second_port_pad_oe)
    );

    // Third port, four pins
    poe_port #(
        .W       (`POE_C_W)
    ) u_third_port (
        .pclk    (pclk),
        .presetn (presetn),
        .regs    (third_port_regs.port),
        .pad_in  (third_port_pad_in),
        .pad_out (third_port_pad_out),
        .pad_oe  (third_port_pad_oe)
    );

    // ****************************************
    // Bus answer
    // ****************************************
    // No wait states: every access completes in
    // its first cycle, which keeps the slave simple
    assign pready  = 1'b1;
    assign pslverr = (state_r == ST_ACCESS) & err_r;
    assign prdata  = prdata_r;

endmodule

`default_nettype wire

// file: core/poe_consts.svh
// Constants for the port output-enable bank: map, widths, reset values
//
// How it works
// - The first port's drive register holds six read/write enables, bits 5..0, 1 drives the pin and 0 leaves it undriven.
// - Bits 7 and 6 of the first port's drive register are read-only and read as zero.
// - The second port's drive register holds eight read/write enables, bits 7..0, 1 drives and 0 does not.
// - The third port's drive register holds four read/write enables, bits 3..0, 1 drives and 0 does not.
// - Bits 7 to 4 of the third port's drive register are read-only and read as zero.
// - Reset clears every enable of all three drive registers, so no pin drives until software sets it.
// - An enabled pin drives its data latch value, and a data read of an output pin returns the latch, not the pad.
// - Reset leaves every pin an undriven input with no pull-up, the data latches cleared but not driven.
`ifndef POE_CONSTS_SVH
`define POE_CONSTS_SVH

// ****************************************
// Register indices as printed
// ****************************************
`define POE_IDX_A_LAT    14'h0000
`define POE_IDX_B_LAT    14'h0001
`define POE_IDX_C_LAT    14'h0002
`define POE_IDX_A_DRV    14'h30B0
`define POE_IDX_B_DRV    14'h30B1
`define POE_IDX_C_DRV    14'h30B2

// ****************************************
// Bus layout
// ****************************************
`define POE_AW           16
`define POE_DW           32
`define POE_BYTE         7:0
`define POE_LANE0        0
`define POE_WORD_LSB     2'h0
`define POE_RDATA_RST    32'h00000000

// ****************************************
// Port widths and reset values
// ****************************************
`define POE_A_W          6
`define POE_B_W          8
`define POE_C_W          4
`define POE_DRV_RST      8'h00
`define POE_LAT_RST      8'h00
`define POE_SYNC_RST     8'h00

`endif

// file: core/poe_pkg.sv
// Types shared by the port output-enable bank
package poe_pkg;

    // Bus phase tracker
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_ACCESS
    } poe_state_t;

    // Which register an address selects
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_A_LAT,
        SEL_A_DRV,
        SEL_B_LAT,
        SEL_B_DRV,
        SEL_C_LAT,
        SEL_C_DRV
    } poe_sel_t;

endpackage

// file: core/poe_port.sv
// One port slice: drive enables, data latch, pad synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "poe_consts.svh"

module poe_port #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    poe_port_if.port          regs,
    input  wire logic [W-1:0] pad_in,
    output logic      [W-1:0] pad_out,
    output logic      [W-1:0] pad_oe
);

    logic [W-1:0] drive_r;
    logic [W-1:0] drive_nxt;
    logic [W-1:0] latch_r;
    logic [W-1:0] latch_nxt;
    logic [W-1:0] sync1_r;
    logic [W-1:0] sync2_r;
    logic [W-1:0] pad_view;

    // ****************************************
    // Register next values
    // ****************************************
    // Only the low W bits are kept; upper written bits vanish
    always_comb begin
        drive_nxt = drive_r;
        latch_nxt = latch_r;
        if (regs.wr_drive) begin
            drive_nxt = regs.wdata[W-1:0];
        end
        if (regs.wr_latch) begin
            latch_nxt = regs.wdata[W-1:0];
        end
    end

    // Cleared at reset: pins float as inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= W'(`POE_DRV_RST);
            latch_r <= W'(`POE_LAT_RST);
            sync1_r <= W'(`POE_SYNC_RST);
            sync2_r <= W'(`POE_SYNC_RST);
        end else begin
            drive_r <= drive_nxt;
            latch_r <= latch_nxt;
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
        end
    end

    // ****************************************
    // Pad drive and read-back
    // ****************************************
    // Outputs read their latch so a loaded pad cannot fool software
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad_view[i] = drive_r[i] ? latch_r[i] : sync2_r[i];
        end
    end

    // Unused upper bits read as zero
    always_comb begin
        regs.drive_rd        = `POE_DRV_RST;
        regs.drive_rd[W-1:0] = drive_r;
        regs.latch_rd        = `POE_LAT_RST;
        regs.latch_rd[W-1:0] = pad_view;
    end

    assign pad_out = latch_r;
    assign pad_oe  = drive_r;

endmodule

`default_nettype wire

// file: core/poe_port_if.sv
// Link between the bus slave and one port slice
`timescale 1ns/100ps
`default_nettype none
`include "poe_consts.svh"

interface poe_port_if;
    logic       wr_drive;
    logic       wr_latch;
    logic [7:0] wdata;
    logic [7:0] drive_rd;
    logic [7:0] latch_rd;

    modport bank (
        output wr_drive,
        output wr_latch,
        output wdata,
        input  drive_rd,
        input  latch_rd
    );

    modport port (
        input  wr_drive,
        input  wr_latch,
        input  wdata,
        output drive_rd,
        output latch_rd
    );
endinterface

`default_nettype wire

// file: dv/poe_bank_properties.sv
// Concurrent checks on the bank's bus and pin ports
`timescale 1ns/100ps
`default_nettype none
`include "poe_consts.svh"

module poe_bank_properties (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic [15:0]        paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [31:0]        pwdata,
    input wire logic [3:0]         pstrb,
    input wire logic [31:0]        prdata,
    input wire logic [5:0]         first_port_pad_out,
    input wire logic [5:0]         first_port_pad_oe,
    input wire logic [7:0]         second_port_pad_out,
    input wire logic [7:0]         second_port_pad_oe,
    input wire logic [3:0]         third_port_pad_out,
    input wire logic [3:0]         third_port_pad_oe
);
    logic wr_ok;
    logic rd_ac;

    // Completed access phases; writes need lane 0
    assign wr_ok = psel && penable && pwrite && pstrb[0];
    assign rd_ac = psel && penable && !pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_a_set;
        wr_ok && paddr == 16'hC2C0 |=>
            first_port_pad_oe == $past(pwdata[5:0]);
    endproperty
    a_a_set: assert property (p_a_set) else $error("first oe wrong");
    property p_b_set;
        wr_ok && paddr == 16'hC2C4 |=>
            second_port_pad_oe == $past(pwdata[7:0]);
    endproperty
    a_b_set: assert property (p_b_set) else $error("second oe wrong");
    property p_c_set;
        wr_ok && paddr == 16'hC2C8 |=>
            third_port_pad_oe == $past(pwdata[3:0]);
    endproperty
    a_c_set: assert property (p_c_set) else $error("third oe wrong");
    property p_a_rd;
        rd_ac && paddr == 16'hC2C0 |-> prdata == {26'h0, first_port_pad_oe};
    endproperty
    a_a_rd: assert property (p_a_rd) else $error("first read wrong");
    property p_c_rd;
        rd_ac && paddr == 16'hC2C8 |-> prdata == {28'h0, third_port_pad_oe};
    endproperty
    a_c_rd: assert property (p_c_rd) else $error("third read wrong");
    property p_hold;
        !(wr_ok && paddr[15:8] == 8'hC2) |=> $stable({first_port_pad_oe,
            second_port_pad_oe, third_port_pad_oe});
    endproperty
    a_hold: assert property (p_hold) else $error("oe moved");
    property p_rst_oe;
        disable iff (1'b0) !presetn |-> {first_port_pad_oe,
            second_port_pad_oe, third_port_pad_oe} == 18'h0;
    endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("oe in reset");
    property p_rst_out;
        disable iff (1'b0) !presetn |-> {first_port_pad_out,
            second_port_pad_out, third_port_pad_out} == 18'h0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("out in reset");
    property p_lat;
        wr_ok && paddr == 16'h0004 |=>
            second_port_pad_out == $past(pwdata[7:0]);
    endproperty
    a_lat: assert property (p_lat) else $error("latch wrong");

    c_wr_a: cover property (wr_ok && paddr == 16'hC2C0);
    c_rd_c: cover property (rd_ac && paddr == 16'hC2C8);
    c_lat: cover property (wr_ok && paddr == 16'h0004);
endmodule

`default_nettype wire

// file: dv/poe_bank_test.sv
// Self-checking bench for the port output-enable bank
`timescale 1ns/100ps
`default_nettype none
`include "poe_consts.svh"

module poe_bank_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        errv;
    logic [3:0]  pstrb;
    logic [5:0]  first_port_pad_in, first_port_pad_out, first_port_pad_oe;
    logic [7:0]  second_port_pad_in, second_port_pad_out, second_port_pad_oe;
    logic [3:0]  third_port_pad_in, third_port_pad_out, third_port_pad_oe;
    logic [17:0] ext_val, ext_en;
    logic [31:0] oe_all, out_all;
    int          error_cnt, checks_done;

    // Pin vectors, third port on top
    assign oe_all = {14'h0, third_port_pad_oe, second_port_pad_oe,
                     first_port_pad_oe};
    assign out_all = {14'h0, third_port_pad_out, second_port_pad_out,
                      first_port_pad_out};

    poe_bank u_poe_bank (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .first_port_pad_in,
        .first_port_pad_out, .first_port_pad_oe, .second_port_pad_in,
        .second_port_pad_out, .second_port_pad_oe, .third_port_pad_in,
        .third_port_pad_out, .third_port_pad_oe);
    poe_pads #(.W(6)) u_poe_pads_a (.pclk, .pad_out(first_port_pad_out),
        .pad_oe(first_port_pad_oe), .ext_val(ext_val[5:0]),
        .ext_en(ext_en[5:0]), .pad_in(first_port_pad_in));
    poe_pads #(.W(8)) u_poe_pads_b (.pclk, .pad_out(second_port_pad_out),
        .pad_oe(second_port_pad_oe), .ext_val(ext_val[13:6]),
        .ext_en(ext_en[13:6]), .pad_in(second_port_pad_in));
    poe_pads #(.W(4)) u_poe_pads_c (.pclk, .pad_out(third_port_pad_out),
        .pad_oe(third_port_pad_oe), .ext_val(ext_val[17:14]),
        .ext_en(ext_en[17:14]), .pad_in(third_port_pad_in));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // One APB transfer, held until pready is seen high; no local limit,
    // only the watchdog may end a wait
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(e, rdv);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk(32'h0, oe_all);
        chk(32'h0, out_all);
        rdchk(16'hC2C0, 32'h0);
        rdchk(16'hC2C4, 32'h0);
        rdchk(16'hC2C8, 32'h0);
    endtask

    // Patterns hit bit order, all ones, reserved-only and clear
    task automatic t_drive();
        logic [7:0] p [5] = '{8'hA5, 8'h5A, 8'hFF, 8'hC0, 8'h00};
        foreach (p[i]) begin
            apb(1'b1, 16'hC2C0, {24'h0, p[i]}, 4'h1);
            apb(1'b1, 16'hC2C4, {24'h0, p[i]}, 4'h1);
            apb(1'b1, 16'hC2C8, {24'h0, p[i]}, 4'h1);
            @(posedge pclk);
            chk({14'h0, p[i][3:0], p[i], p[i][5:0]}, oe_all);
            rdchk(16'hC2C0, {26'h0, p[i][5:0]});
            rdchk(16'hC2C4, {24'h0, p[i]});
            rdchk(16'hC2C8, {28'h0, p[i][3:0]});
        end
    endtask

    // Lane-off write and unmapped write leave enables alone
    task automatic t_refuse();
        apb(1'b1, 16'hC2C4, 32'h3C, 4'h1);
        apb(1'b1, 16'hC2C4, 32'hFF, 4'h0);
        rdchk(16'hC2C4, 32'h3C);
        apb(1'b1, 16'h0010, 32'hFF, 4'hF);
        chk(32'h1, {31'h0, errv});
        chk(32'h0F00, oe_all);
    endtask

    // Driven pins show the latch; outside driver is overridden
    task automatic t_latch();
        ext_val <= 18'h2C3FF;
        apb(1'b1, 16'hC2C0, 32'h3F, 4'h1);
        apb(1'b1, 16'hC2C4, 32'hFF, 4'h1);
        apb(1'b1, 16'hC2C8, 32'h0F, 4'h1);
        apb(1'b1, 16'h0000, 32'h2A, 4'h1);
        apb(1'b1, 16'h0004, 32'h96, 4'h1);
        apb(1'b1, 16'h0008, 32'h09, 4'h1);
        @(posedge pclk);
        chk(32'h265AA, out_all);
        rdchk(16'h0004, 32'h96);
        apb(1'b1, 16'hC2C4, 32'h0F, 4'h1);
        repeat (4) @(posedge pclk);
        chk(32'h0F, {24'h0, second_port_pad_oe});
        rdchk(16'h0004, 32'h06);
    endtask

    // Reset in mid-run drops every enable at once
    task automatic t_mid_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'h0, oe_all);
        chk(32'h0, out_all);
        presetn <= 1'b1;
        rdchk(16'hC2C4, 32'h0);
    endtask

    // ****************************************
    // Clock, main sequence, watchdog
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        // Scheduled so the flops' reset edge cannot be missed at time 0
        presetn <= 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        ext_val = 18'h0;
        ext_en = 18'h3FFFF;
        error_cnt = 0;
        checks_done = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_drive();
        t_refuse();
        t_latch();
        t_mid_reset();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        summarize();
    end
endmodule

bind poe_bank poe_bank_properties u_poe_bank_properties (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .first_port_pad_out, .first_port_pad_oe, .second_port_pad_out,
    .second_port_pad_oe, .third_port_pad_out, .third_port_pad_oe);

`default_nettype wire

// file: dv/poe_pads.sv
// Outside circuitry on one port's pins
`timescale 1ns/100ps
`default_nettype none

module poe_pads #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] pad_in
);
    logic [W-1:0] last_r = '0;

    // No pull-up, so a floating pin toggles rather than sitting at 0
    always_ff @(posedge pclk) begin
        last_r <= pad_in;
    end

    // Wire level: device when enabled, else outside driver or float
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & ~last_r);
endmodule

`default_nettype wire
